// ===== src/mimc_pkg.sv
// constants for the monitor interrupt-mask and configuration register bank
package mimc_pkg;
  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned INTRUSION_PULSE_MS = 20;
  localparam int unsigned INTRUSION_PULSE_CYCLES = (CLK_HZ / 1000) * INTRUSION_PULSE_MS;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_STATUS_ONE = 8'h41;
  localparam logic [7:0] IDX_STATUS_TWO = 8'h42;
  localparam logic [7:0] IDX_MASK_TWO = 8'h44;
  localparam logic [7:0] IDX_INTRUSION_CLEAR = 8'h46;
  localparam logic [7:0] IDX_VID_FAN = 8'h47;
  localparam logic [7:0] IDX_VID_IDENT = 8'h49;
  localparam logic [7:0] IDX_CONFIG_TWO = 8'h4a;
  localparam logic [7:0] IDX_STATUS_ONE_MIRROR = 8'h4c;
  localparam logic [7:0] IDX_STATUS_TWO_MIRROR = 8'h4d;

  // field positions
  localparam int unsigned INTRUSION_CLEAR_BIT = 7;
  localparam int unsigned FAN_ONE_LSB = 4;
  localparam int unsigned FAN_TWO_LSB = 6;
  localparam int unsigned CFG_OVERTEMP_LINE_MASK_BIT = 0;
  localparam int unsigned CFG_AMB_LOCK_BIT = 1;
  localparam int unsigned CFG_REM_LOCK_BIT = 2;
  localparam int unsigned CFG_ACPI_BIT = 3;
  localparam int unsigned CFG_AUX_A_BIT = 6;
  localparam int unsigned CFG_AUX_B_BIT = 7;

  // masks
  localparam logic [7:0] CFG_STORED_MASK = 8'hc9;
  localparam logic [7:0] CFG_LOCK_MASK = 8'h06;
  localparam logic [7:0] STATUS_TWO_VALID = 8'hf3;
  localparam logic [7:0] OVERTEMP_LINE_SRC_ONE = 8'h30;
  localparam logic [7:0] OVERTEMP_LINE_SRC_TWO = 8'h20;

  // values after reset
  localparam logic [7:0] MASK_TWO_RESET = 8'h00;
  localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] FAN_DIV_RESET = 4'h0;

  // arbitrary identification pattern for bits 7:1 of the ident register
  localparam logic [6:0] DEVICE_IDENT = 7'h2a;

  localparam int unsigned FAN_COUNT = 2;
endpackage : mimc_pkg

// ===== src/mimc_regs.sv
// monitor interrupt mask, intrusion clear, voltage id, fan prescale and configuration registers
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
// Functional notes
// - mask-two bits 0,1,4-7 set to one keep their status bit off the interrupt
// - mask-two bits 2 and 3 are plain read/write bits, zero at power-up
// - writing one to intrusion-clear bit 7 drives the intrusion pin low 20 ms
// - intrusion-clear bit drops by itself once the pulse is over
// - intrusion-clear bits 0 to 6 always read zero
// - voltage-id register bits 3:0 show the four core voltage code pins
// - bits 5:4 pick fan one prescale: divide by 1, 2, 4 or 8
// - bits 7:6 pick fan two prescale: divide by 1, 2, 4 or 8
// - ident register bit 0 shows the fifth code pin, bits 7:1 a fixed pattern
// - config bit 0 masks thermal sources from the interrupt only, not overtemp line
// - config bit 1 locks the ambient fan-control register against writes
// - config bit 2 locks the remote fan-control register against writes
// - a lock holds until power-on, hard or soft reset; writing zero keeps it
// - config bit 3 picks overtemp line default mode or ACPI mode
// - config bit 6 enables aux input a as interrupt when channel mode allows
// - config bit 7 enables aux input b as interrupt when channel mode allows
// - config bits 4 and 5 are reserved and read only
// - status one mirror is read only and reports each channel's limit errors
// - status two mirror reports supply, intrusion, overtemp and diode faults
// - mask two, intrusion clear, config two and both mirrors reset to zero
// - reading a primary status register clears all its bits one cycle after sampling; live events re-set
module mimc_regs
  import mimc_pkg::*;
#(
  parameter int unsigned INTRUSION_PULSE = mimc_pkg::INTRUSION_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] status_one_set_i,
  input wire logic [7:0] status_two_set_i,
  input wire logic [7:0] irq_mask_one_i,
  input wire logic [3:0] core_voltage_code_i,
  input wire logic core_voltage_code_msb_i,
  input wire logic channel_mode_irq_i,
  input wire logic analog_in_one_i,
  input wire logic analog_in_two_i,
  input wire logic overtemp_req_i,
  input wire logic [1:0] fan_pulse_i,
  output logic [1:0] fan_tick_o,
  output logic [1:0] fan_one_prescale_o,
  output logic [1:0] fan_two_prescale_o,
  output logic int_n_o,
  output logic overtemp_line_n_o,
  output logic overtemp_acpi_mode_o,
  output logic ambient_fan_lock_o,
  output logic remote_fan_lock_o,
  output logic intrusion_o,
  output logic intrusion_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic ack;
  logic [31:0] rdata;
  logic [7:0] irq_mask_two;
  logic [7:0] config_two;
  logic [3:0] fan_div;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [31:0] pulse_cnt;
  logic int_n;
  logic overtemp_n;
  logic next_ack;
  logic [31:0] next_rdata;
  logic [7:0] next_irq_mask_two;
  logic [7:0] next_config_two;
  logic [3:0] next_fan_div;
  logic [7:0] next_status_one;
  logic [7:0] next_status_two;
  logic [31:0] next_pulse_cnt;
  logic next_int_n;
  logic next_overtemp_n;
  logic [7:0] idx;
  logic take;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_byte;
  logic pulse_active;
  logic pulse_start;
  logic [7:0] pend_one;
  logic [7:0] pend_two;
  logic aux_irq;

  assign idx = wb_adr_i[9:2];
  assign take = wb_cyc_i & wb_stb_i & ~ack;
  assign wr_fire = wb_cyc_i & wb_stb_i & ack & wb_we_i & wb_sel_i[0];
  assign rd_fire = wb_cyc_i & wb_stb_i & ack & ~wb_we_i;
  assign pulse_active = (pulse_cnt != 32'h0);
  assign pulse_start = wr_fire & (idx == IDX_INTRUSION_CLEAR) & wb_dat_i[INTRUSION_CLEAR_BIT] & ~pulse_active;

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  always_comb begin
    case (idx)
      IDX_STATUS_ONE, IDX_STATUS_ONE_MIRROR: rd_byte = status_one;
      IDX_STATUS_TWO, IDX_STATUS_TWO_MIRROR: rd_byte = status_two;
      IDX_MASK_TWO: rd_byte = irq_mask_two;
      IDX_INTRUSION_CLEAR: rd_byte = {pulse_active, 7'h00};
      IDX_VID_FAN: rd_byte = {fan_div, core_voltage_code_i};
      IDX_VID_IDENT: rd_byte = {DEVICE_IDENT, core_voltage_code_msb_i};
      IDX_CONFIG_TWO: rd_byte = config_two;
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources after masking
  always_comb begin
    pend_one = status_one & ~irq_mask_one_i;
    pend_two = status_two & ~irq_mask_two & STATUS_TWO_VALID;
    if (config_two[CFG_OVERTEMP_LINE_MASK_BIT]) begin
      pend_one = pend_one & ~OVERTEMP_LINE_SRC_ONE;
      pend_two = pend_two & ~OVERTEMP_LINE_SRC_TWO;
    end
    aux_irq = channel_mode_irq_i & ((config_two[CFG_AUX_A_BIT] & analog_in_one_i) |
      (config_two[CFG_AUX_B_BIT] & analog_in_two_i));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of the register bank
  always_comb begin
    next_ack = take;
    next_rdata = take ? {24'h000000, rd_byte} : rdata;
    next_irq_mask_two = irq_mask_two;
    next_config_two = config_two;
    next_fan_div = fan_div;
    next_status_one = status_one;
    next_status_two = status_two;
    next_pulse_cnt = pulse_active ? pulse_cnt - 32'h1 : 32'h0;
    if (pulse_start) begin
      next_pulse_cnt = INTRUSION_PULSE;
    end
    if (rd_fire && idx == IDX_STATUS_ONE) begin
      next_status_one = 8'h00;
    end
    if (rd_fire && idx == IDX_STATUS_TWO) begin
      next_status_two = 8'h00;
    end
    // a new event wins over a clear in the same cycle
    next_status_one = next_status_one | status_one_set_i;
    next_status_two = next_status_two | (status_two_set_i & STATUS_TWO_VALID);
    if (wr_fire) begin
      case (idx)
        IDX_MASK_TWO: next_irq_mask_two = wb_dat_i[7:0];
        IDX_VID_FAN: next_fan_div = wb_dat_i[7:4];
        IDX_CONFIG_TWO: begin
          // lock bits only ever set by software
          next_config_two = (wb_dat_i[7:0] & CFG_STORED_MASK) |
            ((wb_dat_i[7:0] | config_two) & CFG_LOCK_MASK);
        end
        default: next_config_two = config_two;
      endcase
    end
    if (soft_reset_i) begin
      next_config_two = CONFIG_TWO_RESET;
      next_irq_mask_two = MASK_TWO_RESET;
      next_fan_div = FAN_DIV_RESET;
      next_status_one = STATUS_RESET;
      next_status_two = STATUS_RESET;
    end
    next_int_n = ~((|pend_one) | (|pend_two) | aux_irq);
    next_overtemp_n = ~overtemp_req_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      irq_mask_two <= MASK_TWO_RESET;
      config_two <= CONFIG_TWO_RESET;
      fan_div <= FAN_DIV_RESET;
      status_one <= STATUS_RESET;
      status_two <= STATUS_RESET;
      pulse_cnt <= 32'h00000000;
      int_n <= 1'b1;
      overtemp_n <= 1'b1;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      irq_mask_two <= next_irq_mask_two;
      config_two <= next_config_two;
      fan_div <= next_fan_div;
      status_one <= next_status_one;
      status_two <= next_status_two;
      pulse_cnt <= next_pulse_cnt;
      int_n <= next_int_n;
      overtemp_n <= next_overtemp_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fan pulse prescalers
  for (genvar f = 0; f < FAN_COUNT; f++) begin : g_fan
    logic [2:0] cnt;
    logic tick;
    logic [2:0] next_cnt;
    logic next_tick;
    logic [1:0] sel;
    logic [2:0] limit;
    always_comb begin
      sel = fan_div[2*f +: 2];
      limit = {sel == 2'h3, sel[1], |sel};
      next_cnt = cnt;
      next_tick = 1'b0;
      if (fan_pulse_i[f]) begin
        if (cnt >= limit) begin
          next_cnt = 3'h0;
          next_tick = 1'b1;
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt <= 3'h0;
        tick <= 1'b0;
      end else begin
        cnt <= next_cnt;
        tick <= next_tick;
      end
    end
    assign fan_tick_o[f] = tick;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign int_n_o = int_n;
  assign overtemp_line_n_o = overtemp_n;
  assign overtemp_acpi_mode_o = config_two[CFG_ACPI_BIT];
  assign ambient_fan_lock_o = config_two[CFG_AMB_LOCK_BIT];
  assign remote_fan_lock_o = config_two[CFG_REM_LOCK_BIT];
  assign fan_one_prescale_o = fan_div[FAN_ONE_LSB-4 +: 2];
  assign fan_two_prescale_o = fan_div[FAN_TWO_LSB-4 +: 2];
  assign intrusion_o = 1'b0;
  assign intrusion_oe_o = pulse_active;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] oe_len;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_len <= 32'h0;
    end else begin
      oe_len <= intrusion_oe_o ? oe_len + 32'h1 : 32'h0;
    end
  end

  a_mask_two_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fire && idx == IDX_MASK_TWO && !soft_reset_i) |=> irq_mask_two == $past(wb_dat_i[7:0]))
    else $error("mask two write not stored");
  a_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    ((status_one & ~irq_mask_one_i) == 8'h00 && (status_two & ~irq_mask_two & STATUS_TWO_VALID) == 8'h00 &&
      !aux_irq) |=> int_n_o)
    else $error("masked status raised interrupt");
  a_reset_zero: assert property (@(posedge clk_i)
    rst_i |=> (irq_mask_two == 8'h00 && config_two == 8'h00 && status_two == 8'h00 && !intrusion_oe_o))
    else $error("register not zero after reset");
  a_pulse_start: assert property (@(posedge clk_i) disable iff (rst_i)
    pulse_start |=> intrusion_oe_o && !intrusion_o && wb_dat_o[7] == 1'b0)
    else $error("intrusion pulse did not start");
  a_pulse_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(intrusion_oe_o) |-> $past(oe_len) == INTRUSION_PULSE - 1)
    else $error("intrusion pulse length wrong");
  a_clear_bits_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && idx == IDX_INTRUSION_CLEAR) |=> wb_dat_o[6:0] == 7'h00 && wb_ack_o)
    else $error("intrusion clear low bits not zero");
  a_vid_reflect: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && idx == IDX_VID_FAN) |=> wb_dat_o[3:0] == $past(core_voltage_code_i))
    else $error("voltage code not reflected");
  a_ident_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && idx == IDX_VID_IDENT) |=> wb_dat_o[7:0] == {DEVICE_IDENT, $past(core_voltage_code_msb_i)})
    else $error("ident register wrong");
  a_lock_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ambient_fan_lock_o && !soft_reset_i) |=> ambient_fan_lock_o)
    else $error("ambient lock released without reset");
  a_status_clear_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_fire && idx == IDX_STATUS_ONE && !soft_reset_i) |=> status_one == $past(status_one_set_i))
    else $error("status one not cleared by read");
  a_mirror_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_fire && idx == IDX_STATUS_ONE_MIRROR && !soft_reset_i) |=>
      status_one == ($past(status_one) | $past(status_one_set_i)))
    else $error("mirror read changed status");
  a_overtemp_free: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 overtemp_line_n_o == !$past(overtemp_req_i))
    else $error("overtemp line gated");

  ////////////////////////////////////////////////////////////////////////////
  // mask two and bus handshake

  a_mask_two_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(wr_fire && idx == IDX_MASK_TWO) && !soft_reset_i) |=> $stable(irq_mask_two))
    else $error("mask two changed without a write");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // intrusion clear pulse

  a_intr_bit_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && idx == IDX_INTRUSION_CLEAR) |=> wb_dat_o[7] == $past(pulse_active))
    else $error("intrusion clear bit does not follow the pulse");

  a_pulse_no_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (pulse_active && wr_fire && idx == IDX_INTRUSION_CLEAR) |=> pulse_cnt == $past(pulse_cnt) - 32'h1)
    else $error("running intrusion pulse restarted");

  ////////////////////////////////////////////////////////////////////////////
  // fan prescalers

  a_fan_div_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fire && idx == IDX_VID_FAN && !soft_reset_i) |=> fan_div == $past(wb_dat_i[7:4]))
    else $error("fan prescale write not stored");

  a_fan_one_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    (fan_div[1:0] == 2'h0 && fan_pulse_i[0]) |=> fan_tick_o[0])
    else $error("fan one divide by one missed a pulse");

  a_fan_two_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    (fan_div[3:2] == 2'h0 && fan_pulse_i[1]) |=> fan_tick_o[1])
    else $error("fan two divide by one missed a pulse");

  a_fan_tick_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    fan_tick_o[0] |-> $past(fan_pulse_i[0]))
    else $error("fan one tick without a pulse");

  ////////////////////////////////////////////////////////////////////////////
  // configuration two

  a_cfg_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    config_two[5:4] == 2'h0)
    else $error("reserved config bits set");

  a_lock_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fire && idx == IDX_CONFIG_TWO && wb_dat_i[1] && !soft_reset_i) |=> ambient_fan_lock_o)
    else $error("ambient lock not set by write");

  a_remote_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (remote_fan_lock_o && !soft_reset_i) |=> remote_fan_lock_o)
    else $error("remote lock released without reset");

  a_acpi_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fire && idx == IDX_CONFIG_TWO && !soft_reset_i) |=> overtemp_acpi_mode_o == $past(wb_dat_i[3]))
    else $error("overtemp mode bit not stored");

  a_aux_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    aux_irq |=> !int_n_o)
    else $error("aux input did not raise interrupt");

  a_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_reset_i |=> (config_two == 8'h00 && irq_mask_two == 8'h00))
    else $error("soft reset left config or mask set");

  ////////////////////////////////////////////////////////////////////////////
  // status two

  a_status_two_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
    status_two[3:2] == 2'h0)
    else $error("reserved status two bits set");

  a_mirror_two_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_fire && idx == IDX_STATUS_TWO_MIRROR && !soft_reset_i) |=>
      status_two == ($past(status_two) | ($past(status_two_set_i) & STATUS_TWO_VALID)))
    else $error("mirror two read changed status");
endmodule : mimc_regs

// ===== tb/mimc_host.sv
// wishbone host model that issues classic single cycles to the register bank
`timescale 1ns/1ns
module mimc_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    wdat_o = 32'h0;
  end

  // request held until ack is sampled high, then released with inverted lines
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    wdat_o <= {24'h0, wd};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    rd = rdat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    sel_o <= 4'hf;
    wdat_o <= ~{24'h0, wd};
  endtask : xfer
endmodule : mimc_host

// ===== tb/tb_top.sv
// self-checking bench for the monitor register bank
`timescale 1ns/1ns
module tb_top;
  import mimc_pkg::*;
  localparam int unsigned PULSE = 8;
  localparam logic [9:0] A_S1 = {IDX_STATUS_ONE, 2'b00};
  localparam logic [9:0] A_S2 = {IDX_STATUS_TWO, 2'b00};
  localparam logic [9:0] A_M2 = {IDX_MASK_TWO, 2'b00};
  localparam logic [9:0] A_IC = {IDX_INTRUSION_CLEAR, 2'b00};
  localparam logic [9:0] A_VF = {IDX_VID_FAN, 2'b00};
  localparam logic [9:0] A_ID = {IDX_VID_IDENT, 2'b00};
  localparam logic [9:0] A_CF = {IDX_CONFIG_TWO, 2'b00};
  localparam logic [9:0] A_R1 = {IDX_STATUS_ONE_MIRROR, 2'b00};
  localparam logic [9:0] A_R2 = {IDX_STATUS_TWO_MIRROR, 2'b00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] status_one_set_i = 8'h00;
  logic [7:0] status_two_set_i = 8'h00;
  logic [7:0] irq_mask_one_i = 8'h00;
  logic [3:0] core_voltage_code_i = 4'h9;
  logic core_voltage_code_msb_i = 1'b1;
  logic channel_mode_irq_i = 1'b0;
  logic analog_in_one_i = 1'b0;
  logic analog_in_two_i = 1'b0;
  logic overtemp_req_i = 1'b0;
  logic [1:0] fan_pulse_i = 2'h0;
  logic [1:0] fan_tick_o, fan_one_prescale_o, fan_two_prescale_o;
  logic int_n_o, overtemp_line_n_o, overtemp_acpi_mode_o;
  logic ambient_fan_lock_o, remote_fan_lock_o, intrusion_o, intrusion_oe_o;
  int errors = 0;
  int total_checks = 0;
  int oe_cnt = 0;
  int tk1 = 0;
  int tk2 = 0;

  always #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (intrusion_oe_o === 1'b1) oe_cnt <= oe_cnt + 1;
    if (fan_tick_o[0] === 1'b1) tk1 <= tk1 + 1;
    if (fan_tick_o[1] === 1'b1) tk2 <= tk2 + 1;
  end

  mimc_regs #(.INTRUSION_PULSE(PULSE)) i_dut (.clk_i, .rst_i, .soft_reset_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .status_one_set_i,
    .status_two_set_i, .irq_mask_one_i, .core_voltage_code_i, .core_voltage_code_msb_i,
    .channel_mode_irq_i, .analog_in_one_i, .analog_in_two_i, .overtemp_req_i, .fan_pulse_i,
    .fan_tick_o, .fan_one_prescale_o, .fan_two_prescale_o, .int_n_o, .overtemp_line_n_o,
    .overtemp_acpi_mode_o, .ambient_fan_lock_o, .remote_fan_lock_o, .intrusion_o, .intrusion_oe_o);

  mimc_host host (.clk_i(clk_i), .ack_i(wb_ack_o), .rdat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .wdat_o(wb_dat_i));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic [7:0] d;
    host.xfer(1'b1, a, v, d);
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.xfer(1'b0, a, 8'h00, d);
    chk(d, e);
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // one-cycle event pulse, then time for status and interrupt to settle
  task automatic ev(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i);
    status_one_set_i <= a;
    status_two_set_i <= b;
    @(posedge clk_i);
    status_one_set_i <= 8'h00;
    status_two_set_i <= 8'h00;
    tick(2);
  endtask : ev

  ////////////////////////////////////////
  task automatic t_reset;
    rdc(A_M2, 8'h00);
    rdc(A_IC, 8'h00);
    rdc(A_CF, 8'h00);
    rdc(A_R1, 8'h00);
    rdc(A_R2, 8'h00);
    rdc(A_VF, {4'h0, core_voltage_code_i});
    rdc(A_ID, {DEVICE_IDENT, core_voltage_code_msb_i});
    chk(int_n_o, 1'b1);
  endtask : t_reset

  task automatic t_mask;
    int bits[6] = '{0, 1, 4, 5, 6, 7};
    wr(A_M2, 8'hff);
    rdc(A_M2, 8'hff);
    wr(10'h3fc, 8'h55);
    rdc(10'h3fc, 8'h00);
    ev(8'h00, 8'hff);
    chk(int_n_o, 1'b1);
    foreach (bits[i]) begin
      wr(A_M2, ~(8'h01 << bits[i]));
      tick(2);
      chk(int_n_o, 1'b0);
      wr(A_M2, 8'hff);
      tick(2);
      chk(int_n_o, 1'b1);
    end
    rdc(A_R2, 8'hf3);
    rdc(A_R2, 8'hf3);
    rdc(A_S2, 8'hf3);
    rdc(A_R2, 8'h00);
    wr(A_M2, 8'h00);
  endtask : t_mask

  task automatic t_config;
    wr(A_CF, 8'hff);
    rdc(A_CF, 8'hcf);
    chk({ambient_fan_lock_o, remote_fan_lock_o, overtemp_acpi_mode_o}, 3'h7);
    wr(A_CF, 8'h00);
    rdc(A_CF, 8'h06);
    chk({ambient_fan_lock_o, remote_fan_lock_o, overtemp_acpi_mode_o}, 3'h6);
    @(posedge clk_i);
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    rdc(A_CF, 8'h00);
    chk({ambient_fan_lock_o, remote_fan_lock_o}, 2'h0);
  endtask : t_config

  task automatic t_thermal;
    wr(A_CF, 8'h01);
    ev(8'h30, 8'h20);
    chk(int_n_o, 1'b1);
    overtemp_req_i <= 1'b1;
    tick(2);
    chk(overtemp_line_n_o, 1'b0);
    overtemp_req_i <= 1'b0;
    wr(A_CF, 8'h00);
    tick(2);
    chk(int_n_o, 1'b0);
    rdc(A_R1, 8'h30);
    rdc(A_S1, 8'h30);
    rdc(A_S2, 8'h20);
    tick(2);
    chk(int_n_o, 1'b1);
  endtask : t_thermal

  task automatic t_aux;
    for (int k = 0; k < 2; k++) begin
      wr(A_CF, (k == 0) ? 8'h40 : 8'h80);
      analog_in_one_i <= (k == 0);
      analog_in_two_i <= (k == 1);
      tick(2);
      chk(int_n_o, 1'b1);
      channel_mode_irq_i <= 1'b1;
      tick(2);
      chk(int_n_o, 1'b0);
      analog_in_one_i <= 1'b0;
      analog_in_two_i <= 1'b0;
      channel_mode_irq_i <= 1'b0;
      tick(2);
    end
    wr(A_CF, 8'h00);
  endtask : t_aux

  task automatic t_intr;
    wr(A_IC, 8'h80);
    rdc(A_IC, 8'h80);
    tick(PULSE + 4);
    chk(oe_cnt, PULSE);
    chk(intrusion_o, 1'b0);
    rdc(A_IC, 8'h00);
    wr(A_IC, 8'h7f);
    rdc(A_IC, 8'h00);
  endtask : t_intr

  task automatic t_fan;
    int a;
    int b;
    for (int c = 0; c < 4; c++) begin
      wr(A_VF, {2'(c), 2'(c), 4'h0});
      rdc(A_VF, {2'(c), 2'(c), core_voltage_code_i});
      chk({fan_two_prescale_o, fan_one_prescale_o}, {2'(c), 2'(c)});
      a = tk1;
      b = tk2;
      repeat (8) begin
        @(posedge clk_i);
        fan_pulse_i <= 2'h3;
        @(posedge clk_i);
        fan_pulse_i <= 2'h0;
      end
      tick(3);
      chk(tk1 - a, 8 >> c);
      chk(tk2 - b, 8 >> c);
    end
  endtask : t_fan

  ////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial begin
    tick(6);
    rst_i <= 1'b0;
    t_reset;
    t_mask;
    t_config;
    t_thermal;
    t_aux;
    t_intr;
    t_fan;
    summarize;
  end

  initial begin
    tick(20000);
    errors++;
    summarize;
  end
endmodule : tb_top
